// File: verif/asio_card_model.sv
// behavioural plug-in interface card on the input/output backplane
`timescale 1ns/100ps
`include "asio_defs.svh"
module asio_card_model
  import asio_pkg::*;
#(
  parameter logic [`ASIO_SEL_W-1:0] SEL      = 6'h0A,
  parameter logic [`ASIO_W-1:0]     BUF_INIT = 16'h5A30
)(
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  asio_io_strobe_s             i_io,
  input  wire logic [`ASIO_SEL_W-1:0] i_select,
  input  wire logic [`ASIO_W-1:0]     i_data,
  output logic                        o_skip_response,
  output logic      [`ASIO_W-1:0]     o_data,
  output logic                        o_flag,
  output logic                        o_ctl
);
  logic [`ASIO_W-1:0] buf_r  = BUF_INIT;
  logic               flag_r = 1'b0;
  logic               ctl_r  = 1'b0;
  wire                hit    = (i_select == SEL);
  assign o_flag = flag_r;
  assign o_ctl = ctl_r;
  // bus not driven by us shows the inverse, so a stale value never passes
  assign o_data = (hit && i_io.input_control_strobe) ? buf_r : ~buf_r;
  assign o_skip_response = hit && ((i_io.skip_flag_set_req && flag_r)
    || (i_io.skip_flag_clear_req && !flag_r));
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      flag_r <= 1'b0;
      ctl_r <= 1'b0;
    end
    else if (hit)
    begin
      if (i_io.flag_set) flag_r <= 1'b1;
      if (i_io.flag_clear) flag_r <= 1'b0;
      if (i_io.ctl_set) ctl_r <= 1'b1;
      if (i_io.ctl_clear) ctl_r <= 1'b0;
      // last edge of the strobe wins, when the data is settled
      if (i_io.output_control_strobe) buf_r <= i_data;
    end
  end
endmodule

// File: verif/asio_sequencer_bench.sv
// self-checking bench of the alter-skip and input/output sequencer
`timescale 1ns/100ps
`include "asio_defs.svh"
module asio_sequencer_bench
  import asio_pkg::*;
;
  logic               i_clk = 1'b0;
  logic               i_reset = 1'b1;
  logic               i_run_set = 1'b0;
  logic [`ASIO_W-1:0] i_mem_word = 16'h0000;
  logic [`ASIO_W-1:0] card_data, io_data, acc_a, acc_b, pc, maddr, exp_pc;
  logic [5:0]         sel;
  logic               skip, flag, ctl, ext, carry, ovf, run, late;
  asio_io_strobe_s    io;
  asio_period_e       period;
  int                 n_fail = 0;
  int                 checks_done = 0;
  // word, acc a, acc b, {card flag, extend, overflow, control}, pc step
  logic [55:0] rows [31] = '{
    56'h0700_FFFF_0000_0_1, 56'h0603_0000_0000_0_1, 56'h0700_FFFF_0000_0_1,
    56'h0406_0000_0000_0_2, 56'h0710_FFFF_0000_0_1, 56'h0415_0000_0000_0_2,
    56'h0408_0000_0000_0_2, 56'h04E0_0000_0000_4_2, 56'h04A0_0000_0000_0_1,
    56'h04C0_0000_0000_4_1, 56'h0440_0000_0000_0_1, 56'h0719_FFFF_0000_0_2,
    56'h0F00_FFFF_FFFF_0_1, 56'h0500_0000_FFFF_0_1, 56'h8441_0000_FFFF_2_1,
    56'h84C1_0000_FFFF_2_2, 56'h8641_0000_FFFF_0_1, 56'h8481_0000_FFFF_0_2,
    56'h854A_5A30_FFFF_0_1, 56'h0D00_5A30_0000_0_1, 56'h0C04_5A30_0001_0_1,
    56'h8D0A_5A30_5A31_0_1, 56'h0600_A5CF_5A31_0_1, 56'h844A_A5CF_5A31_8_1,
    56'h84CA_A5CF_5A31_8_2, 56'h878A_A5CF_5A31_0_1, 56'h848A_A5CF_5A31_0_2,
    56'h8D4A_A5CF_A5CF_0_1, 56'h85CA_A5CF_A5CF_1_1, 56'h8DCA_A5CF_A5CF_0_1,
    56'h1234_A5CF_A5CF_0_1};

  asio_sequencer asio_sequencer_i (.i_clk(i_clk), .i_reset(i_reset), .i_run_set(i_run_set),
    .i_mem_word(i_mem_word), .i_io_data(card_data), .i_skip_response(skip), .o_io(io),
    .o_select(sel), .o_io_data(io_data), .o_acc_a(acc_a), .o_acc_b(acc_b), .o_pc(pc),
    .o_mem_addr(maddr), .o_extend(ext), .o_carry(carry), .o_overflow(ovf), .o_run(run),
    .o_period(period), .o_late(late));
  asio_card_model asio_card_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_io(io),
    .i_select(sel), .i_data(io_data), .o_skip_response(skip), .o_data(card_data),
    .o_flag(flag), .o_ctl(ctl));

  always #4 i_clk = ~i_clk;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask

  // word is presented in early T0 and held for the whole phase
  task automatic exec(input logic [15:0] w);
    int k;
    k = 0;
    while ((period !== ASIO_T0 || late !== 1'b0) && k < 40)
    begin
      @(negedge i_clk);
      k++;
    end
    i_mem_word = w;
    repeat (16) @(negedge i_clk);
  endtask

  task automatic pulse_run;
    i_run_set = 1'b1;
    @(negedge i_clk);
    i_run_set = 1'b0;
  endtask

  task automatic final_report;
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    n_fail++;
    final_report();
  end

  initial
  begin
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    chk("reset pc", 16'h0000, pc);
    chk("reset acc_b", 16'h0000, acc_b);
    chk("reset run", 16'h0000, {15'h0000, run});
    exp_pc = 16'h0000;
    pulse_run();
    foreach (rows[r])
    begin
      exec(rows[r][55:40]);
      exp_pc = exp_pc + {12'h000, rows[r][3:0]};
      chk("acc_a", rows[r][39:24], acc_a);
      chk("acc_b", rows[r][23:8], acc_b);
      chk("extend", {15'h0000, rows[r][6]}, {15'h0000, ext});
      chk("overflow", {15'h0000, rows[r][5]}, {15'h0000, ovf});
      chk("control", {15'h0000, rows[r][4]}, {15'h0000, ctl});
      chk("card flag", {15'h0000, rows[r][7]}, {15'h0000, flag});
      chk("pc", exp_pc, pc);
      chk("mem_addr", exp_pc, maddr);
    end
    exec(16'h8400);
    exp_pc = exp_pc + 16'h0001;
    repeat (8) @(negedge i_clk);
    chk("halted run", 16'h0000, {15'h0000, run});
    chk("halted pc", exp_pc, pc);
    pulse_run();
    exec(16'h0500);
    chk("restart acc_a", 16'h0000, acc_a);
    chk("restart run", 16'h0001, {15'h0000, run});
    // reset dropped into the middle of a running phase
    repeat (6) @(negedge i_clk);
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    chk("mid reset pc", 16'h0000, pc);
    chk("mid reset acc_b", 16'h0000, acc_b);
    chk("mid reset period", 16'h0000, {13'h0000, period});
    final_report();
  end
endmodule

// File: verif/asio_sequencer_chk.sv
// concurrent checks on the ports of the alter-skip and input/output sequencer
`timescale 1ns/100ps
`include "asio_defs.svh"
module asio_sequencer_chk
  import asio_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_skip_response,
  input  asio_io_strobe_s             o_io,
  input  wire logic [`ASIO_SEL_W-1:0] o_select,
  input  wire logic [`ASIO_W-1:0]     o_io_data,
  input  wire logic [`ASIO_W-1:0]     o_acc_a,
  input  wire logic [`ASIO_W-1:0]     o_acc_b,
  input  wire logic [`ASIO_W-1:0]     o_pc,
  input  wire logic [`ASIO_W-1:0]     o_mem_addr,
  input  wire logic                   o_carry,
  input  wire logic                   o_overflow,
  input  wire logic                   o_run,
  input  asio_period_e                o_period,
  input  wire logic                   o_late
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire t6_late = (o_period == ASIO_T6) && o_late;
  wire skip_req = o_io.skip_flag_set_req || o_io.skip_flag_clear_req;
  a_flag_set_t3: assert property (o_io.flag_set |-> o_period == ASIO_T3 && o_run)
    else $error("flag set strobe outside T3");
  a_flag_clr_t4: assert property (o_io.flag_clear |-> o_period == ASIO_T4)
    else $error("flag clear strobe outside T4");
  a_ctl_strobe_t4: assert property ((o_io.ctl_set || o_io.ctl_clear) |-> o_period == ASIO_T4)
    else $error("control strobe outside T4");
  a_skip_req_win: assert property (skip_req |-> o_period inside {ASIO_T3, ASIO_T4})
    else $error("skip request outside T3 and T4");
  a_data_strobe_win: assert property ((o_io.input_control_strobe || o_io.output_control_strobe)
    |-> o_period inside {ASIO_T4, ASIO_T5})
    else $error("data strobe outside T4 and T5");
  a_output_data: assert property ((o_io.output_control_strobe && o_period == ASIO_T5)
    |-> (o_io_data == o_acc_a || o_io_data == o_acc_b))
    else $error("output data is not an accumulator");
  a_skip_to_carry: assert property ((o_period == ASIO_T4 && o_late && skip_req && i_skip_response
    && o_select != `ASIO_SEL_OVF) |=> o_carry)
    else $error("skip response did not set carry");
  a_pc_step: assert property (t6_late |=> o_pc == $past(o_pc) + 16'h0001 + {15'h0000, $past(o_carry)}
    && o_mem_addr == o_pc)
    else $error("pc step wrong");
  a_pc_hold: assert property (!t6_late |=> $stable(o_pc))
    else $error("pc moved outside T6");
  a_carry_clear: assert property ((o_period == ASIO_T0 && o_late) |-> !o_carry)
    else $error("carry not cleared at phase start");
  a_halt_late_t7: assert property (($fell(o_run) && !$past(i_reset))
    |-> $past(o_period) == ASIO_T7 && $past(o_late))
    else $error("run cleared outside late T7");
  a_ovf_select: assert property (($changed(o_overflow) && !$past(i_reset)) |->
    $past(o_select) == `ASIO_SEL_OVF && $past(o_period) inside {ASIO_T3, ASIO_T4})
    else $error("overflow changed without its select code");
  a_period_walk: assert property ((o_period == ASIO_T2 && o_late)
    |=> (o_period == ASIO_T3 && !o_late) ##1 (o_period == ASIO_T3 && o_late))
    else $error("period walk broken");
  c_flag_set: cover property (o_io.flag_set);
  c_skip_taken: cover property (t6_late && o_carry);
  c_halt: cover property ($fell(o_run));
endmodule

bind asio_sequencer asio_sequencer_chk asio_sequencer_chk_i (.i_clk(i_clk), .i_reset(i_reset),
  .i_skip_response(i_skip_response), .o_io(o_io), .o_select(o_select), .o_io_data(o_io_data),
  .o_acc_a(o_acc_a), .o_acc_b(o_acc_b), .o_pc(o_pc), .o_mem_addr(o_mem_addr),
  .o_carry(o_carry), .o_overflow(o_overflow), .o_run(o_run), .o_period(o_period),
  .o_late(o_late));

// File: verilog/asio_alu.sv
// function unit combining the R and S buses onto the T bus
`timescale 1ns/100ps
`include "asio_defs.svh"
module asio_alu
  import asio_pkg::*;
(
  input  wire logic [`ASIO_W-1:0] i_r_bus,
  input  wire logic [`ASIO_W-1:0] i_s_bus,
  input  asio_func_e              i_func,
  input  wire logic               i_carry_in,
  output logic      [`ASIO_W-1:0] o_t_bus
);

  wire [`ASIO_W-1:0] sum = i_r_bus + i_s_bus + {{(`ASIO_W-1){1'b0}}, i_carry_in};
  wire [`ASIO_W-1:0] mix = i_r_bus ^ i_s_bus;

  assign o_t_bus = (i_func == ASIO_F_ADD) ? sum :
                   (i_func == ASIO_F_OR)  ? (i_r_bus | i_s_bus) :
                   (i_func == ASIO_F_INV) ? ~mix : mix;

endmodule

// File: verilog/asio_defs.svh
// constants of the alter-skip and input/output sequencer
`ifndef ASIO_DEFS_SVH
`define ASIO_DEFS_SVH

`define ASIO_W          16
`define ASIO_SEL_W      6
`define ASIO_IR_W       6
// period length: two clock cycles per time period, one per half
`define ASIO_HALVES     2
// instruction-register group fields (ir holds word bits 10 to 15)
`define ASIO_IR_TOP_LO  2
`define ASIO_IR_TOP_HI  5
`define ASIO_IR_B10     0
`define ASIO_IR_ACC     1
`define ASIO_TOP_ALTER  4'h0
`define ASIO_TOP_IO     4'h8
// alter-skip field positions in the T register
`define ASIO_B_RSS      0
`define ASIO_B_SZA      1
`define ASIO_B_INA      2
`define ASIO_B_SLA      3
`define ASIO_B_SSA      4
`define ASIO_B_SEZ      5
`define ASIO_EXT_LO     6
`define ASIO_EXT_HI     7
`define ASIO_ACC_LO     8
`define ASIO_ACC_HI     9
`define ASIO_OP_ZERO    2'h1
`define ASIO_OP_INV     2'h2
`define ASIO_OP_ONES    2'h3
// input/output field positions in the T register
`define ASIO_IO_LO      6
`define ASIO_IO_HI      8
`define ASIO_B_CLRF     9
`define ASIO_B_CTLCLR   11
`define ASIO_IO_HALT    3'h0
`define ASIO_IO_FLAG    3'h1
`define ASIO_IO_SFC     3'h2
`define ASIO_IO_SFS     3'h3
`define ASIO_IO_MERGE   3'h4
`define ASIO_IO_LOAD    3'h5
`define ASIO_IO_OUT     3'h6
`define ASIO_IO_CTL     3'h7
`define ASIO_SEL_OVF    6'h01
// reset values and the increment constant
`define ASIO_RST_WORD   16'h0000
`define ASIO_RST_IR     6'h00
`define ASIO_ONE        16'h0001

`endif

// File: verilog/asio_period_ctr.sv
// time-period counter: eight periods, each split into two halves
`timescale 1ns/100ps
`include "asio_defs.svh"
module asio_period_ctr
  import asio_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_run,
  output asio_period_e      o_period,
  output logic              o_late
);

  asio_period_e period_r;
  logic         late_r;
  // idle only at the first half of T0, so a halt finishes its phase
  wire          advance = i_run | (period_r != ASIO_T0) | late_r;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      period_r <= ASIO_T0;
      late_r   <= 1'b0;
    end
    else if (advance)
    begin
      late_r <= ~late_r;
      if (late_r)
        period_r <= asio_period_e'(period_r + 3'h1);
    end
  end

  assign o_period = period_r;
  assign o_late   = late_r;

endmodule

// File: verilog/asio_pkg.sv
// types of the alter-skip and input/output sequencer
package asio_pkg;

  typedef enum logic [2:0] {
    ASIO_T0 = 3'b000,
    ASIO_T1 = 3'b001,
    ASIO_T2 = 3'b010,
    ASIO_T3 = 3'b011,
    ASIO_T4 = 3'b100,
    ASIO_T5 = 3'b101,
    ASIO_T6 = 3'b110,
    ASIO_T7 = 3'b111
  } asio_period_e;

  typedef enum logic [1:0] {
    ASIO_F_XOR = 2'b00,
    ASIO_F_INV = 2'b01,
    ASIO_F_ADD = 2'b10,
    ASIO_F_OR  = 2'b11
  } asio_func_e;

  typedef struct packed {
    logic flag_set;
    logic flag_clear;
    logic ctl_set;
    logic ctl_clear;
    logic skip_flag_clear_req;
    logic skip_flag_set_req;
    logic input_control_strobe;
    logic output_control_strobe;
  } asio_io_strobe_s;

endpackage

// File: verilog/asio_sequencer.sv
// alter-skip and input/output execution sequencer of the fetch phase
// Functional notes
// RULE_01: T3: one accumulator op, extend test, extend alter
// RULE_02: increment after sign/low tests, before zero test
// RULE_03: skips only read; hit sets carry, skip two
// RULE_04: zero: no reads, xor of zeros stored
// RULE_05: invert: read accumulator, invert, store back
// RULE_06: ones: no reads, inverted zero stored
// RULE_07: extend test against reverse-skip bit before alteration
// RULE_08: bits 7:6 alter extend in late T3
// RULE_09: sign bit test against reverse-skip in T4
// RULE_10: low bit test against reverse-skip in T4
// RULE_11: increment stored in late T5
// RULE_12: or of accumulator tested against reverse-skip
// RULE_13: I/O: clear T, clear IR, load IR, advance
// RULE_14: halt clears run in late T7
// RULE_15: flag-set strobe broadcast in T3
// RULE_16: flag-clear strobe broadcast in T4
// RULE_17: skip requests from T3, response sets carry T4
// RULE_18: merge/load input ORed and stored
// RULE_19: bit 9 clears flag on data transfers
// RULE_20: output places accumulator under output strobe
// RULE_21: control set/clear strobes in T4
// RULE_22: select code one is internal overflow
// RULE_23: pc plus one plus carry into P and M
// RULE_24: carry cleared at start of next phase
// RULE_25: IR bit 11 picks accumulator B
// RULE_26: sign, low and reverse-skip: skip if both
`timescale 1ns/100ps
`include "asio_defs.svh"
module asio_sequencer
  import asio_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_run_set,
  input  wire logic [`ASIO_W-1:0]     i_mem_word,
  input  wire logic [`ASIO_W-1:0]     i_io_data,
  input  wire logic                   i_skip_response,
  output asio_io_strobe_s             o_io,
  output logic      [`ASIO_SEL_W-1:0] o_select,
  output logic      [`ASIO_W-1:0]     o_io_data,
  output logic      [`ASIO_W-1:0]     o_acc_a,
  output logic      [`ASIO_W-1:0]     o_acc_b,
  output logic      [`ASIO_W-1:0]     o_pc,
  output logic      [`ASIO_W-1:0]     o_mem_addr,
  output logic                        o_extend,
  output logic                        o_carry,
  output logic                        o_overflow,
  output logic                        o_run,
  output asio_period_e                o_period,
  output logic                        o_late
);

  logic [`ASIO_W-1:0]    t_r;
  logic [`ASIO_IR_W-1:0] ir_r;
  logic [`ASIO_W-1:0]    acc_a_r;
  logic [`ASIO_W-1:0]    acc_b_r;
  logic [`ASIO_W-1:0]    pc_r;
  logic [`ASIO_W-1:0]    m_r;
  logic [`ASIO_W-1:0]    io_data_r;
  logic                  e_r;
  logic                  carry_r;
  logic                  ovf_r;
  logic                  run_r;
  asio_period_e          period;
  logic                  late;
  logic [`ASIO_W-1:0]    t_bus;

  function automatic logic in_period(input asio_period_e p, input asio_period_e want);
    in_period = (p == want);
  endfunction

  asio_period_ctr u_ctr (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_run    (run_r),
    .o_period (period),
    .o_late   (late)
  );

  wire t0 = in_period(period, ASIO_T0);
  wire t1 = in_period(period, ASIO_T1);
  wire t2 = in_period(period, ASIO_T2);
  wire t3 = in_period(period, ASIO_T3);
  wire t4 = in_period(period, ASIO_T4);
  wire t5 = in_period(period, ASIO_T5);
  wire t6 = in_period(period, ASIO_T6);
  wire t7 = in_period(period, ASIO_T7);
  wire t45 = t4 | t5;
  wire t67 = t6 | t7;

  // group decode from the instruction register
  wire [3:0] ir_top = ir_r[`ASIO_IR_TOP_HI:`ASIO_IR_TOP_LO];
  wire grp_as = (ir_top == `ASIO_TOP_ALTER) & ir_r[`ASIO_IR_B10];
  wire grp_io = (ir_top == `ASIO_TOP_IO) & ir_r[`ASIO_IR_B10];
  wire sel_b  = ir_r[`ASIO_IR_ACC]; // RULE_25
  wire [`ASIO_W-1:0] acc_q = sel_b ? acc_b_r : acc_a_r; // RULE_25

  // alter-skip fields
  wire       reverse_skip_bit = t_r[`ASIO_B_RSS];
  wire [1:0] acc_op  = t_r[`ASIO_ACC_HI:`ASIO_ACC_LO];
  wire [1:0] ext_op  = t_r[`ASIO_EXT_HI:`ASIO_EXT_LO];
  wire zero_accumulator       = grp_as & (acc_op == `ASIO_OP_ZERO);
  wire invert_accumulator     = grp_as & (acc_op == `ASIO_OP_INV);
  wire ones_accumulator       = grp_as & (acc_op == `ASIO_OP_ONES);
  wire skip_extend_zero       = grp_as & t_r[`ASIO_B_SEZ];
  wire skip_sign_test         = grp_as & t_r[`ASIO_B_SSA];
  wire skip_low_bit_test      = grp_as & t_r[`ASIO_B_SLA];
  wire increment_accumulator  = grp_as & t_r[`ASIO_B_INA];
  wire skip_accum_zero        = grp_as & t_r[`ASIO_B_SZA];

  // input/output fields
  wire [2:0] io_op = t_r[`ASIO_IO_HI:`ASIO_IO_LO];
  wire clr_flag_bit  = t_r[`ASIO_B_CLRF];
  wire halt_op       = grp_io & (io_op == `ASIO_IO_HALT);
  wire flag_op       = grp_io & (io_op == `ASIO_IO_FLAG);
  wire flag_set_op   = flag_op & ~clr_flag_bit;
  wire skip_flag_clear_op = grp_io & (io_op == `ASIO_IO_SFC);
  wire skip_flag_set_op   = grp_io & (io_op == `ASIO_IO_SFS);
  wire merge_input   = grp_io & (io_op == `ASIO_IO_MERGE);
  wire load_input    = grp_io & (io_op == `ASIO_IO_LOAD);
  wire output_accumulator = grp_io & (io_op == `ASIO_IO_OUT);
  wire ctl_op        = grp_io & (io_op == `ASIO_IO_CTL);
  wire control_clear_op = ctl_op & t_r[`ASIO_B_CTLCLR];
  wire control_set_op   = ctl_op & ~t_r[`ASIO_B_CTLCLR];
  wire xfer_op = merge_input | load_input | output_accumulator;
  wire flag_clear_op = (flag_op | halt_op | xfer_op) & clr_flag_bit; // RULE_19
  wire ovf_sel = (t_r[`ASIO_SEL_W-1:0] == `ASIO_SEL_OVF);

  // R bus: reads omitted for zero and ones, so the bus stays empty
  wire rd_acc = (t3 & invert_accumulator) // RULE_04 RULE_05 RULE_06
              | (t4 & (skip_sign_test | skip_low_bit_test)) // RULE_09 RULE_10
              | (t5 & (increment_accumulator | skip_accum_zero)) // RULE_11 RULE_12
              | (t45 & (merge_input | output_accumulator)); // RULE_18 RULE_20
  wire [`ASIO_W-1:0] r_bus = rd_acc ? acc_q : (t67 ? pc_r : `ASIO_RST_WORD);
  wire [`ASIO_W-1:0] s_bus =
      (t45 & (merge_input | load_input)) ? i_io_data : // RULE_18
      ((t5 & increment_accumulator) | t67) ? `ASIO_ONE : `ASIO_RST_WORD; // RULE_11

  // ones is the inverted empty bus, zero the xor of empty buses
  wire use_inv = t3 & (invert_accumulator | ones_accumulator); // RULE_05 RULE_06
  wire use_add = (t5 & increment_accumulator) | t67; // RULE_11 RULE_23
  wire use_or  = t45 & (merge_input | load_input); // RULE_18
  asio_func_e func;
  assign func = use_add ? ASIO_F_ADD :
                use_inv ? ASIO_F_INV :
                use_or  ? ASIO_F_OR  : ASIO_F_XOR; // RULE_04

  asio_alu u_alu (
    .i_r_bus    (r_bus),
    .i_s_bus    (s_bus),
    .i_func     (func),
    .i_carry_in (t67 & carry_r), // RULE_23
    .o_t_bus    (t_bus)
  );

  // skip tests: values look at the buses, the extend bit, overflow and the skip response, nothing is stored
  wire sign_ok = (r_bus[`ASIO_W-1] == reverse_skip_bit); // RULE_09
  wire low_ok  = (r_bus[0] == reverse_skip_bit); // RULE_10
  wire both_rev = skip_sign_test & skip_low_bit_test & reverse_skip_bit;
  wire t4_as_hit = both_rev ? (sign_ok & low_ok) : // RULE_26
                   ((skip_sign_test & sign_ok) | (skip_low_bit_test & low_ok));
  // zero test sees the already incremented value on the T bus
  wire zero_hit = skip_accum_zero & ((|t_bus) == reverse_skip_bit); // RULE_02 RULE_12
  wire ext_hit  = skip_extend_zero & (e_r == reverse_skip_bit); // RULE_07
  wire io_skip  = skip_flag_clear_op | skip_flag_set_op;
  wire flag_now = ovf_sel ? (skip_flag_clear_op ? ~ovf_r : ovf_r) : i_skip_response; // RULE_22

  // set events: extend test in early T3, before the late-T3 alteration
  wire carry_set = (t3 & ~late & ext_hit) // RULE_01 RULE_07
                 | (t4 & late & t4_as_hit) // RULE_02 RULE_03
                 | (t5 & late & zero_hit) // RULE_02 RULE_03
                 | (t4 & late & io_skip & flag_now); // RULE_17 RULE_22
  wire carry_clr = t0 & ~late; // RULE_24
  wire carry_nxt = carry_set | (carry_r & ~carry_clr);

  wire acc_we = (t3 & late & grp_as & (acc_op != 2'h0)) // RULE_01 RULE_04
              | (t5 & late & increment_accumulator) // RULE_11
              | (t5 & late & (merge_input | load_input)); // RULE_18

  logic e_nxt;
  always_comb
  begin
    e_nxt = e_r;
    if (t3 & late & grp_as)
    begin
      unique case (ext_op) // RULE_08
        2'h0: e_nxt = e_r;
        2'h1: e_nxt = 1'b0;
        2'h2: e_nxt = ~e_r;
        2'h3: e_nxt = 1'b1;
      endcase
    end
  end

  wire ovf_set = t3 & late & flag_set_op & ovf_sel; // RULE_22
  wire ovf_clr = t4 & late & flag_clear_op & ovf_sel; // RULE_22
  wire halt_now = t7 & late & halt_op; // RULE_14

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      t_r   <= `ASIO_RST_WORD;
      ir_r  <= `ASIO_RST_IR;
      e_r   <= 1'b0;
      carry_r <= 1'b0;
      ovf_r <= 1'b0;
      run_r <= 1'b0;
    end
    else
    begin
      if (t0 & late)
        t_r <= `ASIO_RST_WORD; // RULE_13
      else if (t1 & late)
        t_r <= i_mem_word;
      if (t1 & late)
        ir_r <= `ASIO_RST_IR; // RULE_13
      else if (t2 & late)
        ir_r <= t_r[`ASIO_W-1:`ASIO_W-`ASIO_IR_W]; // RULE_13
      e_r     <= e_nxt; // RULE_08
      carry_r <= carry_nxt; // RULE_03
      ovf_r   <= ovf_set | (ovf_r & ~ovf_clr);
      run_r   <= i_run_set | (run_r & ~halt_now); // RULE_14
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      acc_a_r   <= `ASIO_RST_WORD;
      acc_b_r   <= `ASIO_RST_WORD;
      pc_r      <= `ASIO_RST_WORD;
      m_r       <= `ASIO_RST_WORD;
      io_data_r <= `ASIO_RST_WORD;
    end
    else
    begin
      if (acc_we & ~sel_b)
        acc_a_r <= t_bus;
      if (acc_we & sel_b)
        acc_b_r <= t_bus;
      if (t6 & late)
      begin
        pc_r <= t_bus; // RULE_13 RULE_23
        m_r  <= t_bus; // RULE_23
      end
      io_data_r <= r_bus; // RULE_20
    end
  end

  // backplane strobes are decoded straight from period, T register and the IR group decode
  assign o_io.flag_set   = t3 & flag_set_op; // RULE_15
  assign o_io.flag_clear = t4 & flag_clear_op; // RULE_16 RULE_19
  assign o_io.ctl_set    = t4 & control_set_op; // RULE_21
  assign o_io.ctl_clear  = t4 & control_clear_op; // RULE_21
  assign o_io.skip_flag_clear_req = (t3 | t4) & skip_flag_clear_op; // RULE_17
  assign o_io.skip_flag_set_req   = (t3 | t4) & skip_flag_set_op; // RULE_17
  assign o_io.input_control_strobe  = t45 & (merge_input | load_input); // RULE_18
  assign o_io.output_control_strobe = t45 & output_accumulator; // RULE_20

  assign o_select   = t_r[`ASIO_SEL_W-1:0];
  assign o_io_data  = io_data_r;
  assign o_acc_a    = acc_a_r;
  assign o_acc_b    = acc_b_r;
  assign o_pc       = pc_r;
  assign o_mem_addr = m_r;
  assign o_extend   = e_r;
  assign o_carry    = carry_r;
  assign o_overflow = ovf_r;
  assign o_run      = run_r;
  assign o_period   = period;
  assign o_late     = late;

endmodule
